// ---- src/mbm_pkg.sv ----
// constants, carriers and helpers of the memory module bank mapper
// assumes one processor clock domain and an apb register port
package mbm_pkg;

  // ==========================================================
  // geometry
  localparam int MOD_W      = 4;
  localparam int SLOT_N     = 4;
  localparam int SLOT_W     = 2;
  localparam int OFF_W      = 13;
  localparam int LVL_N      = 64;
  localparam int LVL_W      = 6;
  localparam int SET_W      = MOD_W * SLOT_N;
  localparam int PHYS_W     = MOD_W + OFF_W;
  localparam int HALF_W     = 32;

  // ==========================================================
  // register offsets and reset values
  localparam logic [7:0]  OFF_STAT_LO = 8'h00;
  localparam logic [7:0]  OFF_STAT_HI = 8'h04;
  localparam logic [7:0]  OFF_CLR_LO  = 8'h08;
  localparam logic [7:0]  OFF_CLR_HI  = 8'h0C;
  localparam logic [7:0]  OFF_ACTIVE  = 8'h10;
  localparam logic [7:0]  OFF_SEL_IDX = 8'h14;
  localparam logic [7:0]  OFF_SEL_SET = 8'h18;
  localparam logic [15:0] SET_RESET   = 16'h0000;
  localparam logic [63:0] STAT_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [5:0]  LVL_RESET   = 6'h00;
  localparam int          ACT_SET_LSB = 8;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic [OFF_W-1:0]  word;
  } mbm_op_t;

  typedef struct packed {
    logic [MOD_W-1:0] module_num;
    logic [OFF_W-1:0] word;
  } mbm_mem_t;

  typedef struct packed {
    logic             set_bit;
    logic [LVL_W-1:0] level;
  } mbm_lvl_req_t;

  // ==========================================================
  // pick the module number of one slot out of a set
  function automatic logic [MOD_W-1:0] slot_module(
    input logic [SET_W-1:0]  set_val,
    input logic [SLOT_W-1:0] slot
  );
    slot_module = set_val[slot*MOD_W +: MOD_W];
  endfunction

endpackage

// ---- src/mbm_prio.sv ----
// highest set status bit gives the running program level
// assumes a plain combinational use inside the mapper
`timescale 1ns/1ps
module mbm_prio #(
  parameter int N = 64,
  parameter int W = 6
)(
  input  wire logic [N-1:0] status,
  output logic      [W-1:0] level
);

  // ==========================================================
  // priority encode, level zero when nothing is set
  always_comb
  begin
    level = '0;
    for (int i = 0; i < N; i++)
    begin
      if (status[i])
      begin
        level = W'(i);
      end
    end
  end

endmodule // mbm_prio

// ---- src/mbm_mapper.sv ----
// memory module bank mapper: level tables, status bits, translation
// assumes an apb master on pclk and one processor per instance
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module mbm_mapper #(
  parameter int ADDR_W = 8
)(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    op_valid,
  input  wire mbm_pkg::mbm_op_t        op,
  input  wire logic                    lvl_req_valid,
  input  wire mbm_pkg::mbm_lvl_req_t   lvl_req,
  output logic                         mem_valid,
  output mbm_pkg::mbm_mem_t            mem,
  output logic [mbm_pkg::LVL_W-1:0]    active_level
);

  // ==========================================================
  // state
  logic [mbm_pkg::SET_W-1:0]   set_tab [0:mbm_pkg::LVL_N-1];
  logic [mbm_pkg::LVL_N-1:0]   stat_reg;
  logic [mbm_pkg::LVL_N-1:0]   stat_next;
  logic [mbm_pkg::LVL_W-1:0]   act_lvl_reg;
  logic [mbm_pkg::LVL_W-1:0]   act_lvl_next;
  logic [mbm_pkg::LVL_W-1:0]   sel_idx_reg;
  logic                        pready_reg;
  logic                        pslverr_reg;
  logic [31:0]                 prdata_reg;
  logic                        mem_valid_reg;
  mbm_pkg::mbm_mem_t           mem_reg;

  // ==========================================================
  // apb decode
  wire                         apb_acc;
  wire                         apb_wr;
  wire                         apb_rd;
  wire [7:0]                   addr8;
  wire                         hit_stat_lo;
  wire                         hit_stat_hi;
  wire                         hit_clr_lo;
  wire                         hit_clr_hi;
  wire                         hit_active;
  wire                         hit_sel_idx;
  wire                         hit_sel_set;
  wire                         hit_any;
  wire [mbm_pkg::SET_W-1:0]    act_set;
  wire [mbm_pkg::SET_W-1:0]    idx_set;

  assign apb_acc     = psel & penable & ~pready_reg;
  assign apb_wr      = psel & penable & pready_reg & pwrite;
  assign apb_rd      = apb_acc & ~pwrite;
  assign addr8       = 8'(paddr);
  assign hit_stat_lo = (addr8 == mbm_pkg::OFF_STAT_LO);
  assign hit_stat_hi = (addr8 == mbm_pkg::OFF_STAT_HI);
  assign hit_clr_lo  = (addr8 == mbm_pkg::OFF_CLR_LO);
  assign hit_clr_hi  = (addr8 == mbm_pkg::OFF_CLR_HI);
  assign hit_active  = (addr8 == mbm_pkg::OFF_ACTIVE);
  assign hit_sel_idx = (addr8 == mbm_pkg::OFF_SEL_IDX);
  assign hit_sel_set = (addr8 == mbm_pkg::OFF_SEL_SET);
  assign hit_any     = hit_stat_lo | hit_stat_hi | hit_clr_lo
                     | hit_clr_hi | hit_active | hit_sel_idx
                     | hit_sel_set;
  assign act_set     = set_tab[act_lvl_reg];
  assign idx_set     = set_tab[sel_idx_reg];

  // ==========================================================
  // read data select
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = '0;
    if (hit_stat_lo)
    begin
      rd_val = stat_reg[31:0];
    end
    else if (hit_stat_hi)
    begin
      rd_val = stat_reg[63:32];
    end
    else if (hit_active)
    begin
      rd_val[mbm_pkg::LVL_W-1:0] = act_lvl_reg;
      rd_val[mbm_pkg::ACT_SET_LSB +: mbm_pkg::SET_W] = act_set;
    end
    else if (hit_sel_idx)
    begin
      rd_val[mbm_pkg::LVL_W-1:0] = sel_idx_reg;
    end
    else if (hit_sel_set)
    begin
      rd_val[mbm_pkg::SET_W-1:0] = idx_set;
    end
  end

  // ==========================================================
  // level status bits: set wins over clear
  logic [mbm_pkg::LVL_N-1:0] set_mask;
  logic [mbm_pkg::LVL_N-1:0] clr_mask;
  always_comb
  begin
    set_mask = '0;
    clr_mask = '0;
    if (apb_wr && hit_stat_lo)
    begin
      set_mask[31:0] = pwdata;
    end
    if (apb_wr && hit_stat_hi)
    begin
      set_mask[63:32] = pwdata;
    end
    if (apb_wr && hit_clr_lo)
    begin
      clr_mask[31:0] = pwdata;
    end
    if (apb_wr && hit_clr_hi)
    begin
      clr_mask[63:32] = pwdata;
    end
    if (lvl_req_valid && lvl_req.set_bit)
    begin
      set_mask[lvl_req.level] = 1'b1;
    end
    if (lvl_req_valid && !lvl_req.set_bit)
    begin
      clr_mask[lvl_req.level] = 1'b1;
    end
  end

  assign stat_next = (stat_reg | set_mask) & ~(clr_mask & ~set_mask);

  // ==========================================================
  // running level follows status bits
  mbm_prio #(
    .N (mbm_pkg::LVL_N),
    .W (mbm_pkg::LVL_W)
  ) u_prio (
    .status (stat_reg),
    .level  (act_lvl_next)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_reg    <= mbm_pkg::STAT_RESET;
      act_lvl_reg <= mbm_pkg::LVL_RESET;
    end
    else
    begin
      stat_reg    <= stat_next;
      act_lvl_reg <= act_lvl_next;
    end
  end

  // ==========================================================
  // per-level module sets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < mbm_pkg::LVL_N; i++)
      begin
        set_tab[i] <= mbm_pkg::SET_RESET;
      end
      sel_idx_reg <= mbm_pkg::LVL_RESET;
    end
    else if (apb_wr && hit_active)
    begin
      set_tab[act_lvl_reg] <= pwdata[mbm_pkg::ACT_SET_LSB +: mbm_pkg::SET_W];
    end
    else if (apb_wr && hit_sel_set)
    begin
      set_tab[sel_idx_reg] <= pwdata[mbm_pkg::SET_W-1:0];
    end
    else if (apb_wr && hit_sel_idx)
    begin
      sel_idx_reg <= pwdata[mbm_pkg::LVL_W-1:0];
    end
  end

  // ==========================================================
  // apb answer: one wait state, then ready with data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end
    else
    begin
      pready_reg  <= apb_acc;
      pslverr_reg <= apb_acc & ~hit_any;
      prdata_reg  <= apb_rd ? rd_val : '0;
    end
  end

  // ==========================================================
  // operand translation: slot selects module, word passes through
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_valid_reg <= 1'b0;
      mem_reg       <= '0;
    end
    else
    begin
      mem_valid_reg      <= op_valid;
      mem_reg.module_num <= mbm_pkg::slot_module(act_set, op.slot);
      mem_reg.word       <= op.word;
    end
  end

  // ==========================================================
  // outputs
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign mem_valid    = mem_valid_reg;
  assign mem          = mem_reg;
  assign active_level = act_lvl_reg;

endmodule // mbm_mapper

// ---- tb/mbm_chk.sv ----
// port checker of the bank mapper
// assumes a bind onto mbm_mapper, one clock domain
`timescale 1ns/1ps
module mbm_chk (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  op_valid,
  input wire mbm_pkg::mbm_op_t      op,
  input wire logic                  lvl_req_valid,
  input wire mbm_pkg::mbm_lvl_req_t lvl_req,
  input wire logic                  mem_valid,
  input wire mbm_pkg::mbm_mem_t     mem,
  input wire logic [5:0]            active_level
);
  // ==========================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire q = !lvl_req_valid && !psel;
  property p_mv; op_valid |=> mem_valid; endproperty
  a_mv: assert property (p_mv) else $error("no access");
  property p_wd; op_valid |=> mem.word == $past(op.word); endproperty
  a_wd: assert property (p_wd) else $error("bad word");
  property p_rd; psel && penable && !pready |=> pready; endproperty
  a_rd: assert property (p_rd) else $error("no ready");
  property p_pl; pready |=> !pready; endproperty
  a_pl: assert property (p_pl) else $error("long ready");
  property p_er; pslverr |-> pready && prdata == 32'h0; endproperty
  a_er: assert property (p_er) else $error("bad refusal");
  property p_hd; q [*2] |=> $stable(active_level); endproperty
  a_hd: assert property (p_hd) else $error("level moved");
  property p_cl; q ##1 (lvl_req_valid && !psel && lvl_req.set_bit &&
    lvl_req.level > active_level) ##1 q
    |=> active_level == $past(lvl_req.level, 2); endproperty
  a_cl: assert property (p_cl) else $error("no call");
  property p_rt; q ##1 (lvl_req_valid && !psel && !lvl_req.set_bit &&
    lvl_req.level == active_level && active_level != 6'h00) ##1 q
    |=> active_level < $past(lvl_req.level, 2); endproperty
  a_rt: assert property (p_rt) else $error("no return");
endmodule // mbm_chk

bind mbm_mapper mbm_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .op_valid(op_valid), .op(op),
  .lvl_req_valid(lvl_req_valid), .lvl_req(lvl_req),
  .mem_valid(mem_valid), .mem(mem), .active_level(active_level));

// ---- tb/mbm_mem_model.sv ----
// memory side model: keeps the last module and word reached
// assumes mem and mem_valid straight from the mapper
`timescale 1ns/1ps
module mbm_mem_model (
  input wire logic              pclk,
  input wire logic              mem_valid,
  input wire mbm_pkg::mbm_mem_t mem,
  output mbm_pkg::mbm_mem_t     last
);
  // ==========================================================
  // capture
  always @(posedge pclk)
  begin
    if (mem_valid)
    begin
      last <= mem;
    end
  end
endmodule // mbm_mem_model

// ---- tb/memory_module_bank_mapper_tb.sv ----
// self-checking bench of the memory module bank mapper
// assumes the mapper, its bound checker and the memory model
`timescale 1ns/1ps
module memory_module_bank_mapper_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, op_valid = 1'b0, lvl_req_valid = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, mem_valid, er;
  mbm_pkg::mbm_op_t op = '0;
  mbm_pkg::mbm_lvl_req_t lvl_req = '0;
  mbm_pkg::mbm_mem_t mem, last;
  logic [5:0] active_level;
  int failures = 0, n_tests = 0;
  always #2.5 pclk = ~pclk;
  mbm_mapper dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op(op), .lvl_req_valid(lvl_req_valid),
    .lvl_req(lvl_req), .mem_valid(mem_valid), .mem(mem),
    .active_level(active_level));
  mbm_mem_model u_mem (.pclk(pclk), .mem_valid(mem_valid), .mem(mem),
    .last(last));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 8 && pready !== 1'b1; i++)
      @(posedge pclk);
    if (i == 8)
    begin
      failures++;
      complete_run();
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic xl(input logic [1:0] s, input logic [12:0] w,
                    input logic [3:0] m);
    @(posedge pclk);
    op_valid <= 1'b1;
    op <= {s, w};
    @(posedge pclk);
    op_valid <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk({15'h0, last}, {15'h0, m, w});
  endtask
  task automatic lv(input logic sb, input logic [5:0] l,
                    input logic [5:0] e);
    @(posedge pclk);
    lvl_req_valid <= 1'b1;
    lvl_req <= {sb, l};
    @(posedge pclk);
    lvl_req_valid <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk({26'h0, active_level}, {26'h0, e});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdc(mbm_pkg::OFF_ACTIVE, 32'h0);
    apb(1'b1, mbm_pkg::OFF_SEL_IDX, 32'h3F);
    rdc(mbm_pkg::OFF_SEL_SET, 32'h0);
    xl(2'h3, 13'h1FFF, 4'h0);
  endtask
  task automatic t_sets();
    apb(1'b1, mbm_pkg::OFF_SEL_IDX, 32'h0);
    apb(1'b1, mbm_pkg::OFF_SEL_SET, 32'h5C20);
    apb(1'b1, mbm_pkg::OFF_SEL_IDX, 32'h9);
    apb(1'b1, mbm_pkg::OFF_SEL_SET, 32'hA71F);
    rdc(mbm_pkg::OFF_SEL_SET, 32'hA71F);
    xl(2'h0, 13'h0000, 4'h0);
    xl(2'h1, 13'h1FFF, 4'h2);
    xl(2'h2, 13'h0ABC, 4'hC);
    xl(2'h3, 13'h1000, 4'h5);
  endtask
  task automatic t_call();
    lv(1'b1, 6'h09, 6'h09);
    xl(2'h0, 13'h0123, 4'hF);
    xl(2'h3, 13'h0123, 4'hA);
    lv(1'b0, 6'h09, 6'h00);
    xl(2'h2, 13'h0123, 4'hC);
  endtask
  task automatic t_stat();
    apb(1'b1, mbm_pkg::OFF_STAT_HI, 32'h8000_0000);
    rdc(mbm_pkg::OFF_STAT_HI, 32'h8000_0000);
    rdc(mbm_pkg::OFF_ACTIVE, 32'h3F);
    apb(1'b1, mbm_pkg::OFF_CLR_HI, 32'h8000_0000);
    rdc(mbm_pkg::OFF_ACTIVE, 32'h005C_2000);
  endtask
  task automatic t_direct();
    apb(1'b1, mbm_pkg::OFF_ACTIVE, 32'h003E_4B00);
    rdc(mbm_pkg::OFF_ACTIVE, 32'h003E_4B00);
    xl(2'h1, 13'h0004, 4'h4);
    lv(1'b1, 6'h09, 6'h09);
    xl(2'h1, 13'h0004, 4'h1);
    lv(1'b0, 6'h09, 6'h00);
    xl(2'h3, 13'h0004, 4'h3);
  endtask
  task automatic t_lo();
    apb(1'b1, mbm_pkg::OFF_STAT_LO, 32'h20);
    rdc(mbm_pkg::OFF_STAT_LO, 32'h20);
    rdc(mbm_pkg::OFF_ACTIVE, 32'h05);
    rdc(mbm_pkg::OFF_CLR_LO, 32'h0);
    chk({31'h0, er}, 32'h0);
    apb(1'b1, mbm_pkg::OFF_CLR_LO, 32'h20);
    rdc(mbm_pkg::OFF_STAT_LO, 32'h0);
    rdc(mbm_pkg::OFF_ACTIVE, 32'h003E_4B00);
    rdc(mbm_pkg::OFF_SEL_IDX, 32'h09);
  endtask
  task automatic t_rst2();
    lv(1'b1, 6'h09, 6'h09);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(mbm_pkg::OFF_ACTIVE, 32'h0);
    rdc(mbm_pkg::OFF_STAT_LO, 32'h0);
    apb(1'b1, mbm_pkg::OFF_SEL_IDX, 32'h9);
    rdc(mbm_pkg::OFF_SEL_SET, 32'h0);
    xl(2'h1, 13'h0004, 4'h0);
  endtask
  task automatic t_bad();
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sets();
    t_call();
    t_stat();
    t_direct();
    t_lo();
    t_bad();
    t_rst2();
    complete_run();
  end
endmodule // memory_module_bank_mapper_tb
